// [bench/bmc_conv_model.sv]
// Converter stand-in facing the control core's converter port.
// Assumes one conversion at a time; data is only valid with done.
`timescale 1ns/100ps
`default_nettype none
module bmc_conv_model (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        start_i,
  input  wire logic [7:0]  lat_i,
  input  wire logic [23:0] press_i,
  output var  logic        done_o,
  output var  logic [23:0] press_o,
  output var  logic [15:0] temp_o
);
  logic [7:0] cnt_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) cnt_q <= 8'h00;
    else if (start_i) cnt_q <= lat_i;
    else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
  end
  // Outside done the data inverts, so a stale capture shows up
  assign done_o  = (cnt_q == 8'h01);
  assign press_o = done_o ? press_i : ~press_i;
  assign temp_o  = done_o ? press_i[23:8] : ~press_i[23:8];
endmodule : bmc_conv_model
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the measurement-control core.
// Assumes the converter model beside it and shortened count parameters.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module testbench;
  import bmc_pkg::*;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary value
  logic clk = 0, rst_n = 0, wrs = 0, rds = 0, wml = 1, fmm = 0, done, start;
  logic [6:0]  addr = '0;
  logic [7:0]  wd = '0, rdat, v, lat = 8'h14;
  logic [23:0] pin = '0, pr, dp;
  logic [15:0] tp;
  logic [6:0]  tc;
  logic [9:0]  pc;
  logic sim, i2d, fen, wmf, dv, act, trim;
  int fails = 0, comparisons = 0, ns = 0, nd = 0, cyc = 0, n0;
  bmc_measure_ctl #(.P_DEVICE_ID(ID), .P_RATE_A_CYC(50),
    .P_RATE_B_CYC(20), .P_RATE_C_CYC(16), .P_RATE_D_CYC(10),
    .P_TRIM_CYC(30)) u_bmc_measure_ctl (
    .core_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr),
    .reg_wr_i(wrs), .reg_wdata_i(wd), .reg_rd_i(rds),
    .reg_rdata_o(rdat), .conv_done_i(done), .conv_press_i(pr),
    .conv_temp_i(tp), .fifo_mean_mode_i(fmm),
    .watermark_level_i(wml), .conv_start_o(start), .active_o(act),
    .temp_avg_count_o(tc), .press_avg_count_o(pc),
    .spi_wire_select_o(sim), .two_wire_disable_o(i2d),
    .fifo_enable_o(fen), .watermark_flag_o(wmf), .diff_press_o(dp),
    .diff_valid_o(dv), .trim_reload_o(trim));
  bmc_conv_model u_bmc_conv_model (.core_clk_i(clk), .reset_n_i(rst_n),
    .start_i(start), .lat_i(lat), .press_i(pin), .done_o(done),
    .press_o(pr), .temp_o(tp));
  ////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (start === 1'b1) ns++;
    if (dv === 1'b1) nd++;
    if (cyc == 10000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc
  task automatic wreg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    wd = d;
    wrs = 1;
    @(posedge clk);
    #1 wrs = 0;
  endtask : wreg
  task automatic rreg(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    rds = 1;
    @(posedge clk);
    #1 rds = 0;
    d = rdat;
  endtask : rreg
  task automatic creg(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    rreg(a, d);
    `CHK(d, e)
  endtask : creg
  task automatic shot(input logic [23:0] p, input logic [7:0] c2);
    pin = p;
    wreg(ADDR_CTRL2, c2);
    wait_cyc(int'(lat) + 8);
  endtask : shot
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [9:0] pt [4] = '{10'd8, 10'd32, 10'd128, 10'd512};
    creg(ADDR_ID, ID);
    wreg(ADDR_ID, 8'h00);
    creg(ADDR_ID, ID);
    creg(ADDR_AVG, 8'h0f);
    `CHK(pc, 10'd512)
    for (int i = 0; i < 4; i++) begin
      wreg(ADDR_AVG, {4'h0, i[1:0], i[1:0]});
      `CHK(tc, 7'd8 << i)
      `CHK(pc, pt[i])
    end
  endtask : t_reset
  task automatic t_ctrl();
    `CHK({sim, i2d, fen, wmf}, 4'h0)
    wreg(ADDR_CTRL1, 8'h01);
    `CHK(sim, 1'b1)
    wreg(ADDR_CTRL2, 8'h68);
    wait_cyc(2);
    `CHK({i2d, fen, wmf}, 3'h7)
    #1 wml = 0;
    wait_cyc(2);
    `CHK(wmf, 1'b0)
    wreg(ADDR_CTRL1, 8'h00);
    wreg(ADDR_CTRL2, 8'h00);
    `CHK({sim, i2d, fen}, 3'h0)
  endtask : t_ctrl
  task automatic t_shot();
    n0 = ns;
    shot(24'h123456, 8'h01);
    `CHK(ns - n0, 0)
    wreg(ADDR_CTRL2, 8'h00);
    wreg(ADDR_CTRL1, 8'h80);
    `CHK(act, 1'b1)
    pin = 24'h123456;
    wreg(ADDR_CTRL2, 8'h01);
    wait_cyc(4);
    wreg(ADDR_CTRL2, 8'h00);
    creg(ADDR_CTRL2, 8'h01);
    wait_cyc(30);
    `CHK(ns - n0, 1)
    creg(ADDR_CTRL2, 8'h00);
    creg(ADDR_STATUS, 8'h03);
    creg(ADDR_POUT_XL, 8'h56);
    creg(ADDR_POUT_H, 8'h12);
    creg(ADDR_STATUS, 8'h01);
    `CHK(nd, 0)
  endtask : t_shot
  task automatic t_rate();
    int per [5] = '{50, 20, 16, 10, 0};
    lat = 8'h03;
    for (int r = 1; r <= 5; r++) begin
      wreg(ADDR_CTRL1, 8'h80 | 8'(r << 4));
      n0 = ns;
      // First start lands one cycle after the first tick
      wait_cyc(105);
      if (r == 5) `CHK(ns - n0, 0)
      else `CHK((ns - n0) * per[r-1] / 10 inside {[9:11]}, 1'b1)
      wreg(ADDR_CTRL1, 8'h80);
      wait_cyc(6);
    end
  endtask : t_rate
  task automatic t_ref();
    wreg(ADDR_REF_L, 8'h01);
    wreg(ADDR_CTRL1, 8'h88);
    n0 = nd;
    shot(24'h000180, 8'h01);
    `CHK(nd - n0, 1)
    `CHK(dp, 24'h000080)
    wreg(ADDR_CTRL1, 8'h80);
    shot(24'h000180, 8'h01);
    `CHK(nd - n0, 1)
    shot(24'h100000, 8'h01);
    wreg(ADDR_CTRL2, 8'h02);
    creg(ADDR_REF_H, 8'h10);
    shot(24'h0ffff0, 8'h03);
    creg(ADDR_POUT_XL, 8'hf0);
    creg(ADDR_POUT_H, 8'hff);
    wreg(ADDR_PRESSURE_OFFSET_L, 8'h55);
    wreg(ADDR_CTRL1, 8'h82);
    creg(ADDR_REF_H, 8'h00);
    creg(ADDR_PRESSURE_OFFSET_L, 8'h00);
    creg(ADDR_CTRL1, 8'h80);
  endtask : t_ref
  task automatic t_bdu();
    wreg(ADDR_CTRL1, 8'h84);
    rreg(ADDR_POUT_XL, v);
    rreg(ADDR_POUT_H, v);
    shot(24'haa0000, 8'h01);
    rreg(ADDR_POUT_XL, v);
    shot(24'hbb0000, 8'h01);
    creg(ADDR_POUT_H, 8'haa);
    shot(24'hcc0000, 8'h01);
    creg(ADDR_POUT_H, 8'hcc);
  endtask : t_bdu
  task automatic t_swr();
    wreg(ADDR_AVG, 8'h00);
    wreg(ADDR_CTRL1, 8'h81);
    wreg(ADDR_CTRL2, 8'h04);
    wait_cyc(SWRST_CYC + 5);
    creg(ADDR_CTRL1, 8'h00);
    creg(ADDR_AVG, 8'h0f);
    creg(ADDR_CTRL2, 8'h00);
    wreg(ADDR_CTRL2, 8'h80);
    `CHK(trim, 1'b1)
    wait_cyc(35);
    `CHK(trim, 1'b0)
    creg(ADDR_CTRL2, 8'h00);
  endtask : t_swr
  task automatic t_dec();
    fmm = 1;
    pin = 24'h222222;
    wreg(ADDR_CTRL2, 8'h10);
    wreg(ADDR_CTRL1, 8'hc0);
    wait_cyc(20);
    creg(ADDR_POUT_H, 8'h00);
    wait_cyc(40);
    creg(ADDR_POUT_H, 8'h22);
    fmm = 0;
    pin = 24'h333333;
    wait_cyc(15);
    creg(ADDR_POUT_H, 8'h33);
  endtask : t_dec
  ////////////////////////////////////////////////////////////////////
  initial begin
    wait_cyc(20);
    #1 rst_n = 1;
    t_reset();
    t_ctrl();
    t_shot();
    t_rate();
    t_ref();
    t_bdu();
    t_swr();
    t_dec();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire

// [core/bmc_measure_ctl.sv]
// Measurement control and register file of the barometer core.
// Assumes a byte register port on the core clock (from the serial
// front end) and a converter that answers conv_start_o with conv_done_i.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RULE1: Temperature averaging 8/16/32/64, resets to 11
// RULE2: Pressure averaging 8/32/128/512, resets to 11
// RULE3: Power-down until power bit written one
// RULE4: Rate field picks 1/7/12.5/25 Hz
// RULE5: Rate 000 means single conversion on trigger
// RULE6: Trigger runs one conversion, then self-clears
// RULE7: Differential output only while enable bit set
// RULE8: Host programs reference before setting differential
// RULE9: Lock holds outputs until both halves read
// RULE10: Zero-clear resets reference and offset, self-clears
// RULE11: Wire-select chooses four or three wire
// RULE12: Trim reload lasts 2.2 ms, then self-clears
// RULE13: FIFO operates only while enable set
// RULE14: Watermark flag maintained only when enabled
// RULE15: Mean decimate updates pressure once per second; no 1 Hz tick at rate 000, so there pressure never updates
// RULE16: Two-wire port ignored when disable bit set
// RULE17: Soft reset restores defaults within 4 us
// RULE18: Host issues soft reset before trim reload
// RULE19: Autozero copies output, then subtracts reference
// RULE20: Reference is 24-bit two's complement, subtracted
// RULE21: Pressure ready set on sample, cleared reading top
// RULE22: Trigger during running conversion is ignored
// RULE23: Identity register is read-only fixed code
module bmc_measure_ctl
  import bmc_pkg::*;
#(
  // Arbitrary identity value
  parameter logic [7:0]  P_DEVICE_ID  = 8'h5a,
  parameter int unsigned P_RATE_A_CYC = RATE_A_CYC,
  parameter int unsigned P_RATE_B_CYC = RATE_B_CYC,
  parameter int unsigned P_RATE_C_CYC = RATE_C_CYC,
  parameter int unsigned P_RATE_D_CYC = RATE_D_CYC,
  parameter int unsigned P_TRIM_CYC   = TRIM_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [6:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  output var  logic [7:0]  reg_rdata_o,
  input  wire logic        conv_done_i,
  input  wire logic [23:0] conv_press_i,
  input  wire logic [15:0] conv_temp_i,
  input  wire logic        fifo_mean_mode_i,
  input  wire logic        watermark_level_i,
  output var  logic        conv_start_o,
  output var  logic        active_o,
  output var  logic [6:0]  temp_avg_count_o,
  output var  logic [9:0]  press_avg_count_o,
  output var  logic        spi_wire_select_o,
  output var  logic        two_wire_disable_o,
  output var  logic        fifo_enable_o,
  output var  logic        watermark_flag_o,
  output var  logic [23:0] diff_press_o,
  output var  logic        diff_valid_o,
  output var  logic        trim_reload_o
);
  typedef struct packed {
    logic [1:0]  tavg;
    logic [1:0]  pavg;
    logic [6:0]  tcnt;
    logic [9:0]  pcnt;
    logic        pwr;
    logic [2:0]  rate;
    logic        differential_enable;
    logic        block_update_lock;
    logic        sim;
    logic        fifo_en;
    logic        wm_en;
    logic        wm_flag;
    logic        dec;
    logic        two_wire_disable;
    logic        swr;
    logic [8:0]  swr_cnt;
    logic        boot;
    logic [23:0] boot_cnt;
    logic        az;
    logic        oneshot;
    logic        busy;
    logic        start;
    logic [23:0] ref_p;
    logic [15:0] pressure_offset;
    logic [23:0] praw;
    logic [23:0] pout;
    logic [15:0] tout;
    logic [23:0] diff;
    logic        diff_vld;
    logic        p_da;
    logic        t_da;
    logic        p_or;
    logic        t_or;
    logic        p_lo_rd;
    logic        p_hi_rd;
    logic        t_lo_rd;
    logic        t_hi_rd;
    logic [7:0]  rdata;
  } bmc_state_t;

  function automatic logic [6:0] tavg_cnt(input logic [1:0] c);
    return 7'h08 << c;
  endfunction : tavg_cnt

  function automatic logic [9:0] pavg_cnt(input logic [1:0] c);
    return 10'h008 << {c, 1'b0};
  endfunction : pavg_cnt

  // Two's complement wrap is intended; no saturation
  function automatic logic [23:0] sub24(input logic [23:0] a,
                                        input logic [23:0] b);
    return a - b;
  endfunction : sub24

  localparam bmc_state_t ST_RST = '{
    tavg: AVG_RST, pavg: AVG_RST,
    tcnt: tavg_cnt(AVG_RST), pcnt: pavg_cnt(AVG_RST),
    rate: RATE_ONE,
    p_lo_rd: 1'b1, p_hi_rd: 1'b1, t_lo_rd: 1'b1, t_hi_rd: 1'b1,
    default: '0
  };

  bmc_state_t q;
  bmc_state_t d;
  bmc_rate_if rif ();

  logic [7:0]  w;
  logic        sample;
  logic        decim;
  logic        p_upd;
  logic [23:0] p_val;

  assign w        = reg_wdata_i;
  assign sample   = conv_done_i && q.busy;
  assign decim    = fifo_mean_mode_i && q.dec;
  assign rif.run  = q.pwr && (q.rate != RATE_ONE) && (q.rate <= RATE_25HZ);
  assign rif.sel  = q.rate;

  bmc_rate_gen #(
    .P_RATE_A_CYC (P_RATE_A_CYC),
    .P_RATE_B_CYC (P_RATE_B_CYC),
    .P_RATE_C_CYC (P_RATE_C_CYC),
    .P_RATE_D_CYC (P_RATE_D_CYC)
  ) u_rate (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .rate       (rif.gen)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d          = q;
    d.start    = 1'b0;
    d.diff_vld = 1'b0;
    d.rdata    = 8'h00;
    p_upd      = 1'b0;
    p_val      = conv_press_i;
    if (q.swr) begin
      // Bus traffic is dropped while the reset sequence runs
      d         = ST_RST; // RULE17
      d.swr     = 1'b1;
      d.swr_cnt = q.swr_cnt + 9'h1;
      if (q.swr_cnt == 9'(SWRST_CYC - 1)) begin
        d.swr     = 1'b0; // RULE17
        d.swr_cnt = '0;
      end
    end else begin
      if (q.boot) begin
        d.boot_cnt = q.boot_cnt + 24'h1;
        if (q.boot_cnt == 24'(P_TRIM_CYC - 1)) begin
          d.boot     = 1'b0; // RULE12
          d.boot_cnt = '0;
        end
      end
      if (reg_wr_i) begin
        if (reg_addr_i == ADDR_REF_XL) begin
          d.ref_p[7:0] = w;
        end else if (reg_addr_i == ADDR_REF_L) begin
          d.ref_p[15:8] = w;
        end else if (reg_addr_i == ADDR_REF_H) begin
          d.ref_p[23:16] = w;
        end else if (reg_addr_i == ADDR_AVG) begin
          d.tavg = w[AVG_T_LO+:2]; // RULE1
          d.pavg = w[AVG_P_LO+:2]; // RULE2
        end else if (reg_addr_i == ADDR_CTRL1) begin
          d.pwr     = w[C1_PWR]; // RULE3
          d.rate    = w[C1_RATE+:3]; // RULE4
          d.differential_enable = w[C1_DIFF];
          d.block_update_lock     = w[C1_BDU];
          d.sim     = w[C1_SIM]; // RULE11
          if (w[C1_AZR]) begin
            // Not stored, so it always reads back as zero
            d.ref_p = '0; // RULE10
            d.pressure_offset  = '0; // RULE10
            d.az    = 1'b0;
          end
        end else if (reg_addr_i == ADDR_CTRL2) begin
          d.fifo_en = w[C2_FIFO]; // RULE13
          d.wm_en   = w[C2_WM];
          d.dec     = w[C2_DEC];
          d.two_wire_disable = w[C2_I2C]; // RULE16
          d.swr     = w[C2_SWR];
          if (w[C2_BOOT] && !q.boot) begin
            d.boot = 1'b1; // RULE12
          end
          if (w[C2_AZ] && !q.az) begin
            d.ref_p = q.pout; // RULE19
          end
          d.az = w[C2_AZ];
          if (!q.busy) begin
            d.oneshot = w[C2_ONE]; // RULE22
          end
        end else if (reg_addr_i == ADDR_PRESSURE_OFFSET_L) begin
          d.pressure_offset[7:0] = w;
        end else if (reg_addr_i == ADDR_PRESSURE_OFFSET_H) begin
          d.pressure_offset[15:8] = w;
        end
      end
      if (reg_rd_i) begin
        if (reg_addr_i == ADDR_REF_XL) begin
          d.rdata = q.ref_p[7:0];
        end else if (reg_addr_i == ADDR_REF_L) begin
          d.rdata = q.ref_p[15:8];
        end else if (reg_addr_i == ADDR_REF_H) begin
          d.rdata = q.ref_p[23:16];
        end else if (reg_addr_i == ADDR_ID) begin
          d.rdata = P_DEVICE_ID; // RULE23
        end else if (reg_addr_i == ADDR_AVG) begin
          d.rdata = {4'h0, q.tavg, q.pavg};
        end else if (reg_addr_i == ADDR_CTRL1) begin
          d.rdata = {q.pwr, q.rate, q.differential_enable, q.block_update_lock, 1'b0, q.sim};
        end else if (reg_addr_i == ADDR_CTRL2) begin
          d.rdata = {q.boot, q.fifo_en, q.wm_en, q.dec,
                     q.two_wire_disable, q.swr, q.az, q.oneshot};
        end else if (reg_addr_i == ADDR_STATUS) begin
          d.rdata = {2'h0, q.p_or, q.t_or, 2'h0, q.p_da, q.t_da};
        end else if (reg_addr_i == ADDR_POUT_XL) begin
          d.rdata   = q.pout[7:0];
          d.p_lo_rd = 1'b1;
        end else if (reg_addr_i == ADDR_POUT_L) begin
          d.rdata = q.pout[15:8];
        end else if (reg_addr_i == ADDR_POUT_H) begin
          d.rdata   = q.pout[23:16];
          d.p_hi_rd = 1'b1;
          d.p_da    = 1'b0; // RULE21
          d.p_or    = 1'b0;
        end else if (reg_addr_i == ADDR_TOUT_L) begin
          d.rdata   = q.tout[7:0];
          d.t_lo_rd = 1'b1;
        end else if (reg_addr_i == ADDR_TOUT_H) begin
          d.rdata   = q.tout[15:8];
          d.t_hi_rd = 1'b1;
          d.t_da    = 1'b0;
          d.t_or    = 1'b0;
        end else if (reg_addr_i == ADDR_PRESSURE_OFFSET_L) begin
          d.rdata = q.pressure_offset[7:0];
        end else if (reg_addr_i == ADDR_PRESSURE_OFFSET_H) begin
          d.rdata = q.pressure_offset[15:8];
        end
      end
      // New sample; its flag sets win over a read in the same cycle
      if (sample) begin
        d.busy    = 1'b0;
        d.oneshot = 1'b0; // RULE6
        d.praw    = conv_press_i;
        d.p_or    = d.p_or | d.p_da;
        d.p_da    = 1'b1; // RULE21
        d.t_or    = d.t_or | d.t_da;
        d.t_da    = 1'b1;
        if (!(q.block_update_lock && !(q.t_lo_rd && q.t_hi_rd))) begin
          d.tout    = conv_temp_i; // RULE9
          d.t_lo_rd = !q.block_update_lock;
          d.t_hi_rd = !q.block_update_lock;
        end
        if (q.differential_enable) begin
          d.diff     = sub24(conv_press_i, q.ref_p); // RULE7 RULE20
          d.diff_vld = 1'b1;
        end
        p_upd = !decim; // RULE15
      end
      if (decim && rif.tick_1hz) begin
        p_upd = 1'b1; // RULE15
        p_val = q.praw;
      end
      if (p_upd && !(q.block_update_lock && !(q.p_lo_rd && q.p_hi_rd))) begin
        d.pout    = q.az ? sub24(p_val, q.ref_p) : p_val; // RULE19 RULE9
        d.p_lo_rd = !q.block_update_lock;
        d.p_hi_rd = !q.block_update_lock;
      end
      if (q.pwr && !q.busy) begin
        if ((q.rate == RATE_ONE && q.oneshot) || rif.tick) begin
          d.start = 1'b1; // RULE3 RULE5
          d.busy  = 1'b1;
        end
      end
      d.wm_flag = q.wm_en && watermark_level_i; // RULE14
    end
    d.tcnt = tavg_cnt(d.tavg); // RULE1
    d.pcnt = pavg_cnt(d.pavg); // RULE2
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign reg_rdata_o        = q.rdata;
  assign conv_start_o       = q.start;
  assign active_o           = q.pwr;
  assign temp_avg_count_o   = q.tcnt;
  assign press_avg_count_o  = q.pcnt;
  assign spi_wire_select_o  = q.sim;
  assign two_wire_disable_o = q.two_wire_disable;
  assign fifo_enable_o      = q.fifo_en;
  assign watermark_flag_o   = q.wm_flag;
  assign diff_press_o       = q.diff;
  assign diff_valid_o       = q.diff_vld;
  assign trim_reload_o      = q.boot;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_temp_avg_map: assert property ( // RULE1
    reg_wr_i && reg_addr_i == ADDR_AVG && !q.swr |=>
      temp_avg_count_o == tavg_cnt($past(reg_wdata_i[AVG_T_LO+:2])))
    else $error("temperature averaging count wrong");

  a_press_avg_map: assert property ( // RULE2
    reg_wr_i && reg_addr_i == ADDR_AVG && !q.swr |=>
      press_avg_count_o == pavg_cnt($past(reg_wdata_i[AVG_P_LO+:2])))
    else $error("pressure averaging count wrong");

  a_power_down_idle: assert property ( // RULE3
    conv_start_o |-> $past(q.pwr))
    else $error("conversion started in power-down");

  a_oneshot_source: assert property ( // RULE5
    conv_start_o |-> $past(q.rate) != RATE_ONE || $past(q.oneshot))
    else $error("start in single mode without trigger");

  a_oneshot_done: assert property ( // RULE6
    sample && !q.swr |=> !q.oneshot && !q.busy && q.p_da)
    else $error("trigger not cleared after conversion");

  a_busy_hold_trig: assert property ( // RULE22
    q.busy && q.oneshot && !conv_done_i && !q.swr |=> q.oneshot && q.busy)
    else $error("trigger lost during running conversion");

  a_diff_gate: assert property ( // RULE7
    diff_valid_o |-> $past(q.differential_enable)
      && diff_press_o == $past(conv_press_i) - $past(q.ref_p))
    else $error("differential output without enable");

  a_lock_hold: assert property ( // RULE9
    q.block_update_lock && !(q.p_lo_rd && q.p_hi_rd) && !q.swr |=> $stable(q.pout))
    else $error("locked pressure output changed");

  a_zero_clear: assert property ( // RULE10
    reg_wr_i && reg_addr_i == ADDR_CTRL1 && reg_wdata_i[C1_AZR] && !q.swr
      |=> q.ref_p == 24'h0 && q.pressure_offset == 16'h0 && !q.az)
    else $error("zero clear left reference set");

  a_soft_reset_end: assert property ( // RULE17
    q.swr && q.swr_cnt == 9'(SWRST_CYC - 1) |=> !q.swr && !q.pwr
      && q.rate == RATE_ONE && q.tavg == AVG_RST)
    else $error("soft reset did not complete");

  a_trim_end: assert property ( // RULE12
    q.boot && !q.swr && q.boot_cnt == 24'(P_TRIM_CYC - 1) |=> !q.boot)
    else $error("trim reload did not self-clear");

  a_ready_set_win: assert property ( // RULE21
    sample && !q.swr |=> q.p_da ##1 (!$past(reg_rd_i
      && reg_addr_i == ADDR_POUT_H) || $past(sample) || !q.p_da))
    else $error("pressure ready flag wrong");
endmodule : bmc_measure_ctl
`default_nettype wire

// [core/bmc_pkg.sv]
// Constants shared by the barometer measurement-control block.
// Assumes a 100 MHz core clock; every count below is derived from it.
package bmc_pkg;
  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned CLK_NS     = 10;
  // Sample rates in tenths of a hertz
  localparam int unsigned RATE_A_DHZ = 10;
  localparam int unsigned RATE_B_DHZ = 70;
  localparam int unsigned RATE_C_DHZ = 125;
  localparam int unsigned RATE_D_DHZ = 250;
  localparam int unsigned RATE_A_CYC = CLK_HZ / RATE_A_DHZ * 10;
  localparam int unsigned RATE_B_CYC = CLK_HZ / RATE_B_DHZ * 10;
  localparam int unsigned RATE_C_CYC = CLK_HZ / RATE_C_DHZ * 10;
  localparam int unsigned RATE_D_CYC = CLK_HZ / RATE_D_DHZ * 10;
  localparam int unsigned TRIM_US    = 2200;
  localparam int unsigned TRIM_CYC   = TRIM_US * 1000 / CLK_NS;
  localparam int unsigned SWRST_NS   = 4000;
  localparam int unsigned SWRST_CYC  = SWRST_NS / CLK_NS;

  localparam logic [6:0] ADDR_REF_XL  = 7'h08;
  localparam logic [6:0] ADDR_REF_L   = 7'h09;
  localparam logic [6:0] ADDR_REF_H   = 7'h0a;
  localparam logic [6:0] ADDR_ID      = 7'h0f;
  localparam logic [6:0] ADDR_AVG     = 7'h10;
  localparam logic [6:0] ADDR_CTRL1   = 7'h20;
  localparam logic [6:0] ADDR_CTRL2   = 7'h21;
  localparam logic [6:0] ADDR_STATUS  = 7'h27;
  localparam logic [6:0] ADDR_POUT_XL = 7'h28;
  localparam logic [6:0] ADDR_POUT_L  = 7'h29;
  localparam logic [6:0] ADDR_POUT_H  = 7'h2a;
  localparam logic [6:0] ADDR_TOUT_L  = 7'h2b;
  localparam logic [6:0] ADDR_TOUT_H  = 7'h2c;
  localparam logic [6:0] ADDR_PRESSURE_OFFSET_L  = 7'h39;
  localparam logic [6:0] ADDR_PRESSURE_OFFSET_H  = 7'h3a;

  // Field positions
  localparam int unsigned AVG_T_LO = 2;
  localparam int unsigned AVG_P_LO = 0;
  localparam int unsigned C1_PWR   = 7;
  localparam int unsigned C1_RATE  = 4;
  localparam int unsigned C1_DIFF  = 3;
  localparam int unsigned C1_BDU   = 2;
  localparam int unsigned C1_AZR   = 1;
  localparam int unsigned C1_SIM   = 0;
  localparam int unsigned C2_BOOT  = 7;
  localparam int unsigned C2_FIFO  = 6;
  localparam int unsigned C2_WM    = 5;
  localparam int unsigned C2_DEC   = 4;
  localparam int unsigned C2_I2C   = 3;
  localparam int unsigned C2_SWR   = 2;
  localparam int unsigned C2_AZ    = 1;
  localparam int unsigned C2_ONE   = 0;

  // Reset values and rate codes
  localparam logic [1:0] AVG_RST   = 2'h3;
  localparam logic [2:0] RATE_ONE  = 3'h0;
  localparam logic [2:0] RATE_1HZ  = 3'h1;
  localparam logic [2:0] RATE_7HZ  = 3'h2;
  localparam logic [2:0] RATE_12HZ = 3'h3;
  localparam logic [2:0] RATE_25HZ = 3'h4;
endpackage : bmc_pkg

// [core/bmc_rate_gen.sv]
// Sample-rate and one-second tick generator for the control core.
// Assumes sel is stable while run is high; a change restarts nothing.
`timescale 1ns/100ps
`default_nettype none
module bmc_rate_gen
  import bmc_pkg::*;
#(
  parameter int unsigned P_RATE_A_CYC = RATE_A_CYC,
  parameter int unsigned P_RATE_B_CYC = RATE_B_CYC,
  parameter int unsigned P_RATE_C_CYC = RATE_C_CYC,
  parameter int unsigned P_RATE_D_CYC = RATE_D_CYC
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  bmc_rate_if.gen  rate
);
  typedef struct packed {
    logic [26:0] cnt;
    logic [26:0] sec;
    logic        tick;
    logic        tick_1hz;
  } bmc_tick_t;

  bmc_tick_t q;
  bmc_tick_t d;

  function automatic logic [26:0] period(input logic [2:0] sel);
    case (sel)
      RATE_7HZ:  return 27'(P_RATE_B_CYC - 1);
      RATE_12HZ: return 27'(P_RATE_C_CYC - 1);
      RATE_25HZ: return 27'(P_RATE_D_CYC - 1);
      default:   return 27'(P_RATE_A_CYC - 1);
    endcase
  endfunction : period

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d          = q;
    d.tick     = 1'b0;
    d.tick_1hz = 1'b0;
    if (!rate.run) begin
      d.cnt = '0;
      d.sec = '0;
    end else begin
      // Compare with >= so a shorter period never overshoots
      if (q.cnt >= period(rate.sel)) begin
        d.cnt  = '0;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + 27'h1;
      end
      if (q.sec >= period(RATE_1HZ)) begin
        d.sec      = '0;
        d.tick_1hz = 1'b1;
      end else begin
        d.sec = q.sec + 27'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rate.tick     = q.tick;
  assign rate.tick_1hz = q.tick_1hz;
endmodule : bmc_rate_gen
`default_nettype wire

// [core/bmc_rate_if.sv]
// Carries the sample-rate selection and ticks between the control core
// and its rate generator. Both ends sit on the same core clock.
`timescale 1ns/100ps
`default_nettype none
interface bmc_rate_if;
  logic       run;
  logic [2:0] sel;
  logic       tick;
  logic       tick_1hz;
  modport gen  (input run, input sel, output tick, output tick_1hz);
  modport user (output run, output sel, input tick, input tick_1hz);
endinterface : bmc_rate_if
`default_nettype wire
